// [hdl/tcu_timer.v]
// Top of the 8-bit timer: counter, mode decode, two compare units, flags.
// Assumes a processor side with one-cycle write strobes and interrupt acknowledge pulses.
`include "tcu_consts.vh"
module tcu_timer (
    input wire clk,
    input wire resetn,
    input wire [2:0] clock_source_select,
    input wire [4:0] prescale_taps,
    input wire external_count_pin,
    input wire [1:0] waveform_mode_low,
    input wire waveform_mode_high,
    input wire [1:0] compare_output_mode_a,
    input wire [1:0] compare_output_mode_b,
    input wire wr_count,
    input wire wr_compare_a,
    input wire wr_compare_b,
    input wire [7:0] wr_data,
    input wire force_compare_strobe_a,
    input wire force_compare_strobe_b,
    input wire [2:0] flag_write_one,
    input wire [2:0] irq_enable,
    input wire [2:0] irq_ack,
    output reg [7:0] timer_count,
    output reg [7:0] compare_value_a_read,
    output reg [7:0] compare_value_b_read,
    output reg overflow_flag,
    output reg compare_flag_a,
    output reg compare_flag_b,
    output reg compare_output_state_a,
    output reg compare_output_state_b,
    output reg [2:0] irq_request,
    output reg bottom,
    output reg at_max
);
    wire timer_tick;
    wire [2:0] wgm;
    wire pwm_mode;
    wire phase_mode;
    wire [7:0] top_value;
    wire at_top;
    wire at_bottom;
    wire load_point;
    wire [7:0] cva;
    wire [7:0] cvb;
    wire [7:0] bufa;
    wire [7:0] bufb;
    wire flag_a;
    wire flag_b;
    wire state_a;
    wire state_b;
    wire match_a;
    wire match_b;
    wire ovf_set;
    wire [2:0] flags;
    reg [7:0] count_reg;
    reg [7:0] count_next;
    reg count_down_reg;
    reg count_down_next;
    reg block_reg;
    reg ovf_reg;

    assign wgm = {waveform_mode_high, waveform_mode_low};
    assign phase_mode = (wgm == `TCU_WGM_PC_FF) || (wgm == `TCU_WGM_PC_TOPA);
    assign pwm_mode = phase_mode || (wgm == `TCU_WGM_FAST_FF) || (wgm == `TCU_WGM_FAST_TOPA);
    assign top_value = (wgm == `TCU_WGM_CTC || wgm[2]) ? cva : `TCU_MAX;
    assign at_top = count_reg == top_value;
    assign at_bottom = count_reg == `TCU_BOTTOM;
    assign load_point = (wgm == `TCU_WGM_FAST_TOPA) ? at_bottom : at_top;
    // Overflow point per mode; phase correct sets at bottom, TOP-A fast at top
    assign ovf_set = timer_tick && !wr_count && (phase_mode ? (at_bottom && count_down_reg) :
        (wgm == `TCU_WGM_FAST_TOPA) ? at_top : (count_reg == `TCU_MAX));

    tcu_tick_select u_tick (
        .clk(clk),
        .resetn(resetn),
        .clock_source_select(clock_source_select),
        .prescale_taps(prescale_taps),
        .external_count_pin(external_count_pin),
        .timer_tick(timer_tick)
    );

    always @* begin
        count_next = count_reg;
        count_down_next = count_down_reg;
        if (timer_tick) begin
            if (phase_mode) begin
                if (at_top)
                    count_down_next = 1'b1;
                else if (at_bottom)
                    count_down_next = 1'b0;
                if (count_down_next)
                    count_next = count_reg - 8'h01;
                else
                    count_next = count_reg + 8'h01;
            end else begin
                count_down_next = 1'b0;
                if (at_top && wgm != `TCU_WGM_NORMAL)
                    count_next = `TCU_COUNT_RESET;
                else
                    count_next = count_reg + 8'h01;
            end
        end
        if (wr_count)
            count_next = wr_data;
    end

    tcu_compare_unit u_cmp_a (
        .clk(clk),
        .resetn(resetn),
        .count(count_reg),
        .timer_tick(timer_tick),
        .pwm_mode(pwm_mode),
        .phase_mode(phase_mode),
        .count_down(count_down_reg),
        .at_top(at_top),
        .at_bottom(at_bottom),
        .load_point(load_point),
        .block_match(block_reg),
        .compare_output_mode(compare_output_mode_a),
        .wr_compare(wr_compare_a),
        .wr_data(wr_data),
        .force_strobe(force_compare_strobe_a),
        .flag_clear(flag_write_one[1] || irq_ack[1]),
        .compare_value(cva),
        .buffer_value(bufa),
        .compare_flag(flag_a),
        .compare_output_state(state_a),
        .match(match_a)
    );

    tcu_compare_unit u_cmp_b (
        .clk(clk),
        .resetn(resetn),
        .count(count_reg),
        .timer_tick(timer_tick),
        .pwm_mode(pwm_mode),
        .phase_mode(phase_mode),
        .count_down(count_down_reg),
        .at_top(at_top),
        .at_bottom(at_bottom),
        .load_point(load_point),
        .block_match(block_reg),
        .compare_output_mode(compare_output_mode_b),
        .wr_compare(wr_compare_b),
        .wr_data(wr_data),
        .force_strobe(force_compare_strobe_b),
        .flag_clear(flag_write_one[2] || irq_ack[2]),
        .compare_value(cvb),
        .buffer_value(bufb),
        .compare_flag(flag_b),
        .compare_output_state(state_b),
        .match(match_b)
    );

    assign flags = {flag_b, flag_a, ovf_reg};

    always @(posedge clk) begin
        if (!resetn) begin
            count_reg <= `TCU_COUNT_RESET;
            count_down_reg <= 1'b0;
            block_reg <= 1'b0;
            ovf_reg <= 1'b0;
            timer_count <= 8'h00;
            compare_value_a_read <= 8'h00;
            compare_value_b_read <= 8'h00;
            overflow_flag <= 1'b0;
            compare_flag_a <= 1'b0;
            compare_flag_b <= 1'b0;
            compare_output_state_a <= 1'b0;
            compare_output_state_b <= 1'b0;
            irq_request <= 3'h0;
            bottom <= 1'b1;
            at_max <= 1'b0;
        end else begin
            count_reg <= count_next;
            count_down_reg <= count_down_next;
            // Block held until the next tick, so a stopped timer still blocks
            if (wr_count)
                block_reg <= 1'b1;
            else if (timer_tick)
                block_reg <= 1'b0;
            // Set beats clear so an event on the clearing cycle is kept
            if (ovf_set)
                ovf_reg <= 1'b1;
            else if (flag_write_one[0] || irq_ack[0])
                ovf_reg <= 1'b0;
            timer_count <= count_next;
            compare_value_a_read <= pwm_mode ? bufa : cva;
            compare_value_b_read <= pwm_mode ? bufb : cvb;
            overflow_flag <= ovf_reg;
            compare_flag_a <= flag_a;
            compare_flag_b <= flag_b;
            compare_output_state_a <= state_a;
            compare_output_state_b <= state_b;
            irq_request <= flags & irq_enable;
            bottom <= count_next == `TCU_BOTTOM;
            at_max <= count_next == `TCU_MAX;
        end
    end
endmodule // tcu_timer

// [common/tcu_consts.vh]
// Constants for the 8-bit timer counter and compare unit.
// Assumes a single system clock; timer_tick comes from an outside prescaler selector.
// Summary of operation
// - Bottom indication is high whenever timer_count equals zero.
// - Count value 255 is the maximum, signalled to the waveform logic.
// - Top is fixed 255 or compare_value_a, depending on the operating mode.
// - Timer tick source is chosen by the three-bit clock_source_select field.
// - Select value zero gives no tick; the counter stays stopped.
// - Each tick clears, increments or decrements the count per mode and direction.
// - Processor may read and write timer_count at any time.
// - A processor count write beats a simultaneous clear or count.
// - Waveform mode: two low bits in control_a, high bit in control_b.
// - Overflow flag sets at the mode-defined point and may request an interrupt.
// - Count is compared continuously with both compare values.
// - Compare flag sets one timer clock after the match.
// - A set, enabled flag requests an interrupt; servicing clears it.
// - Writing one to a flag bit clears it; zero leaves it.
// - PWM modes buffer compare values, loading at top or bottom; others do not.
// - Compare writes go to the buffer while buffering, else to the active value.
// - In non-PWM modes a force strobe forces that unit's match output.
// - Forced match updates the output per mode, no flag, no counter clear.
// - After a count write, matches in the next timer clock are suppressed.
// - Output states are kept across waveform mode changes.
// - Output mode changes take effect at once, unbuffered.
// - Non-PWM output mode: 00 off, 01 toggle, 10 clear, 11 set.
// - Output states reset to zero on system reset.
`ifndef TCU_CONSTS_VH
`define TCU_CONSTS_VH
`define TCU_BOTTOM 8'h00
`define TCU_MAX 8'hff
`define TCU_COUNT_RESET 8'h00
`define TCU_WGM_NORMAL 3'h0
`define TCU_WGM_PC_FF 3'h1
`define TCU_WGM_CTC 3'h2
`define TCU_WGM_FAST_FF 3'h3
`define TCU_WGM_PC_TOPA 3'h5
`define TCU_WGM_FAST_TOPA 3'h7
`define TCU_COM_OFF 2'h0
`define TCU_COM_TOGGLE 2'h1
`define TCU_COM_CLEAR 2'h2
`define TCU_COM_SET 2'h3
`define TCU_CS_STOP 3'h0
`define TCU_CS_EXT_FALL 3'h6
`define TCU_CS_EXT_RISE 3'h7
`endif

// [hdl/tcu_tick_select.v]
// Timer tick source selector.
// Assumes prescaler taps are one-cycle enables on clk and the count pin is asynchronous.
`include "tcu_consts.vh"
module tcu_tick_select (
    input wire clk,
    input wire resetn,
    input wire [2:0] clock_source_select,
    input wire [4:0] prescale_taps,
    input wire external_count_pin,
    output reg timer_tick
);
    reg [2:0] pin_sync_reg;
    reg pin_level_reg;
    wire pin_agree;
    wire rise;
    wire fall;
    assign pin_agree = pin_sync_reg[2] == pin_sync_reg[1];
    assign rise = pin_agree && pin_sync_reg[1] && !pin_level_reg;
    assign fall = pin_agree && !pin_sync_reg[1] && pin_level_reg;
    always @(posedge clk) begin
        if (!resetn) begin
            pin_sync_reg <= 3'h0;
            pin_level_reg <= 1'b0;
            timer_tick <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], external_count_pin};
            if (pin_agree)
                pin_level_reg <= pin_sync_reg[1];
            case (clock_source_select)
                `TCU_CS_STOP: timer_tick <= 1'b0;
                `TCU_CS_EXT_FALL: timer_tick <= fall;
                `TCU_CS_EXT_RISE: timer_tick <= rise;
                default: timer_tick <= prescale_taps[clock_source_select - 3'h1];
            endcase
        end
    end
endmodule // tcu_tick_select

// [hdl/tcu_compare_unit.v]
// One output compare unit: buffered compare value, match flag and output state.
// Assumes the counter shares clk and resetn and gives one-cycle tick and write pulses.
`include "tcu_consts.vh"
module tcu_compare_unit (
    input wire clk,
    input wire resetn,
    input wire [7:0] count,
    input wire timer_tick,
    input wire pwm_mode,
    input wire phase_mode,
    input wire count_down,
    input wire at_top,
    input wire at_bottom,
    input wire load_point,
    input wire block_match,
    input wire [1:0] compare_output_mode,
    input wire wr_compare,
    input wire [7:0] wr_data,
    input wire force_strobe,
    input wire flag_clear,
    output reg [7:0] compare_value,
    output reg [7:0] buffer_value,
    output reg compare_flag,
    output reg compare_output_state,
    output wire match
);
    reg act;
    reg next_state;
    assign match = (count == compare_value) && !block_match;
    always @* begin
        act = 1'b0;
        next_state = compare_output_state;
        if (!pwm_mode) begin
            act = (timer_tick && match) || force_strobe;
            case (compare_output_mode)
                `TCU_COM_TOGGLE: next_state = !compare_output_state;
                `TCU_COM_CLEAR: next_state = 1'b0;
                `TCU_COM_SET: next_state = 1'b1;
                default: act = 1'b0;
            endcase
        end else if (compare_output_mode[1]) begin
            if (phase_mode) begin
                act = timer_tick && match;
                next_state = compare_output_mode[0] ^ count_down;
            end else begin
                act = timer_tick && (match || at_bottom);
                next_state = at_bottom ? !compare_output_mode[0] : compare_output_mode[0];
            end
        end else if (compare_output_mode[0] && at_top) begin
            act = 1'b0;
        end
    end
    always @(posedge clk) begin
        if (!resetn) begin
            compare_value <= 8'h00;
            buffer_value <= 8'h00;
            compare_flag <= 1'b0;
            compare_output_state <= 1'b0;
        end else begin
            if (wr_compare) begin
                buffer_value <= wr_data;
                if (!pwm_mode)
                    compare_value <= wr_data;
            end
            if (pwm_mode && timer_tick && load_point)
                compare_value <= buffer_value;
            if (timer_tick && match)
                compare_flag <= 1'b1;
            else if (flag_clear)
                compare_flag <= 1'b0;
            if (act)
                compare_output_state <= next_state;
        end
    end
endmodule // tcu_compare_unit

// [sim/tcu_timer_sva.sv]
// Checker for the timer top: count, flags, irq and output state.
// Assumes it is bound to tcu_timer and sees its ports only.
module tcu_timer_sva (
    input wire clk,
    input wire resetn,
    input wire [2:0] clock_source_select,
    input wire [4:0] prescale_taps,
    input wire [1:0] waveform_mode_low,
    input wire waveform_mode_high,
    input wire [1:0] compare_output_mode_a,
    input wire wr_count,
    input wire [7:0] wr_data,
    input wire force_compare_strobe_a,
    input wire [2:0] flag_write_one,
    input wire [2:0] irq_enable,
    input wire [7:0] timer_count,
    input wire compare_flag_a,
    input wire compare_output_state_a,
    input wire [2:0] irq_request,
    input wire bottom,
    input wire at_max
);
    wire nrm = waveform_mode_low == 2'h0 && !waveform_mode_high;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_bottom;
        bottom == (timer_count == 8'h00);
    endproperty
    a_bottom: assert property (p_bottom) else $error("bottom wrong");
    property p_max;
        at_max == (timer_count == 8'hff);
    endproperty
    a_max: assert property (p_max) else $error("max wrong");
    property p_write;
        wr_count |=> timer_count == $past(wr_data);
    endproperty
    a_write: assert property (p_write) else $error("count write lost");
    property p_step;
        clock_source_select == 3'h1 && prescale_taps[0] && nrm ##1 nrm && !wr_count
            |=> timer_count == $past(timer_count) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count step wrong");
    property p_stop;
        clock_source_select == 3'h0 && $past(clock_source_select) == 3'h0 && $past(clock_source_select, 2) == 3'h0
            && !$past(wr_count) |-> $stable(timer_count);
    endproperty
    a_stop: assert property (p_stop) else $error("stopped count moved");
    property p_clear;
        flag_write_one[1] && clock_source_select == 3'h0 && $past(clock_source_select) == 3'h0
            |-> ##2 !compare_flag_a;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_irq;
        irq_request[1] == (compare_flag_a && $past(irq_enable[1]));
    endproperty
    a_irq: assert property (p_irq) else $error("irq wrong");
    property p_off;
        compare_output_mode_a == 2'h0 && $past(compare_output_mode_a) == 2'h0
            && $past(compare_output_mode_a, 2) == 2'h0 |-> $stable(compare_output_state_a);
    endproperty
    a_off: assert property (p_off) else $error("output moved while off");
    property p_force;
        force_compare_strobe_a && !compare_flag_a && clock_source_select == 3'h0
            && $past(clock_source_select) == 3'h0 && $past(clock_source_select, 2) == 3'h0
            |-> !compare_flag_a [*3];
    endproperty
    a_force: assert property (p_force) else $error("force set flag");
endmodule // tcu_timer_sva
bind tcu_timer tcu_timer_sva u_sva (.clk(clk), .resetn(resetn), .clock_source_select(clock_source_select),
    .prescale_taps(prescale_taps), .waveform_mode_low(waveform_mode_low), .waveform_mode_high(waveform_mode_high),
    .compare_output_mode_a(compare_output_mode_a), .wr_count(wr_count), .wr_data(wr_data),
    .force_compare_strobe_a(force_compare_strobe_a), .flag_write_one(flag_write_one), .irq_enable(irq_enable),
    .timer_count(timer_count), .compare_flag_a(compare_flag_a), .compare_output_state_a(compare_output_state_a),
    .irq_request(irq_request), .bottom(bottom), .at_max(at_max));

// [sim/tcu_timer_bench.sv]
// Self-checking bench for the timer top: count, select, flags, force, buffers.
// Assumes tcu_timer with its checker bound; the bench drives every port.
module tcu_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg [2:0] sel = 3'h0;
    reg [4:0] taps = 5'h00;
    reg ext = 1'b0, wmh = 1'b0, wc = 1'b0, wa = 1'b0, wb = 1'b0, fa = 1'b0, fb = 1'b0, ms = 1'b0;
    reg [1:0] wml = 2'h0, coma = 2'h0, comb = 2'h0;
    reg [7:0] wd = 8'h00, d;
    reg [2:0] fw = 3'h0, ie = 3'h0, ack = 3'h0;
    wire [7:0] cnt, rda, rdb;
    wire ovf, fla, flb, sta, stb, bot, mx;
    wire [2:0] irq;
    integer n_fail = 0, compares = 0, i, u, c;
    always #4 clk = ~clk;
    tcu_timer dut (.clk(clk), .resetn(resetn), .clock_source_select(sel), .prescale_taps(taps),
        .external_count_pin(ext), .waveform_mode_low(wml), .waveform_mode_high(wmh), .compare_output_mode_a(coma),
        .compare_output_mode_b(comb), .wr_count(wc), .wr_compare_a(wa), .wr_compare_b(wb), .wr_data(wd),
        .force_compare_strobe_a(fa), .force_compare_strobe_b(fb), .flag_write_one(fw), .irq_enable(ie),
        .irq_ack(ack), .timer_count(cnt), .compare_value_a_read(rda), .compare_value_b_read(rdb),
        .overflow_flag(ovf), .compare_flag_a(fla), .compare_flag_b(flb), .compare_output_state_a(sta),
        .compare_output_state_b(stb), .irq_request(irq), .bottom(bot), .at_max(mx));
    function [7:0] add(input [7:0] a, input [7:0] b);
        add = a + b;
    endfunction
    // Output state after a match for a given output mode
    function fst(input s, input [1:0] m);
        fst = m == 2'h1 ? ~s : m == 2'h2 ? 1'b0 : m == 2'h3 ? 1'b1 : s;
    endfunction
    task chk(input [7:0] seen, input [7:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input integer k, input [7:0] v);
        @(posedge clk) begin wd <= v; wc <= k == 0; wa <= k == 1; wb <= k == 2; end
        @(posedge clk) {wc, wa, wb} <= 3'h0;
        #1;
    endtask
    // Taps pulse every other cycle so each pulse is a separate tick
    task tk(input [4:0] m, input integer n);
        repeat (n) begin
            @(posedge clk) taps <= m;
            @(posedge clk) taps <= 5'h00;
        end
    endtask
    task pf(input [2:0] w, input [2:0] a);
        @(posedge clk) begin fw <= w; ack <= a; end
        @(posedge clk) begin fw <= 3'h0; ack <= 3'h0; end
        wt(3);
    endtask
    task fo(input [1:0] m);
        @(posedge clk) begin coma <= m; comb <= m; fa <= 1'b1; fb <= 1'b1; end
        @(posedge clk) {fa, fb} <= 2'h0;
        wt(4);
    endtask
    task stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail = n_fail + 1;
        stop_test;
    end
    initial begin
        c = $urandom(32'heace);
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        wt(1);
        chk(cnt, 8'h00);
        chk({7'h00, bot}, 8'h01);
        chk({6'h00, sta, stb}, 8'h00);
        $display("test reset done");
        for (i = 0; i < 10; i = i + 1) begin
            d = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
            wr(0, d);
            chk(cnt, d);
            chk({6'h00, bot, mx}, {6'h00, d == 8'h00, d == 8'hff});
        end
        $display("test write done");
        for (i = 1; i < 8; i = i + 1) begin
            @(posedge clk) begin sel <= 3'h0; ext <= i == 6; end
            d = 8'($urandom);
            wr(0, d);
            wt(4);
            @(posedge clk) sel <= 3'(i);
            if (i < 6) begin
                tk(~5'(1 << (i - 1)), 1);
                tk(5'(1 << (i - 1)), 1);
            end else begin
                @(posedge clk) ext <= ~ext;
            end
            wt(8);
            chk(cnt, add(d, 8'h01));
        end
        @(posedge clk) sel <= 3'h0;
        tk(5'h1f, 3);
        wt(4);
        chk(cnt, add(d, 8'h01));
        $display("test select done");
        for (u = 0; u < 2; u = u + 1) begin
            c = 2 + $urandom % 200;
            wr(1 + u, 8'(c));
            pf(3'h7, 3'h0);
            @(posedge clk) begin sel <= 3'h1; ie <= 3'h6; end
            wr(0, 8'(c));
            tk(5'h01, 1);
            wt(6);
            chk({7'h00, u ? flb : fla}, 8'h00);
            chk(u ? rdb : rda, 8'(c));
            wr(0, 8'(c - 1));
            tk(5'h01, 2);
            wt(6);
            chk({7'h00, u ? flb : fla}, 8'h01);
            chk({7'h00, irq[1 + u]}, 8'h01);
            pf(3'h1, 3'h0);
            chk({7'h00, u ? flb : fla}, 8'h01);
            pf(u ? 3'h4 : 3'h0, u ? 3'h0 : 3'h2);
            chk({7'h00, u ? flb : fla}, 8'h00);
        end
        $display("test compare done");
        @(posedge clk) ie <= 3'h7;
        wr(0, 8'hfe);
        tk(5'h01, 2);
        wt(6);
        chk(cnt, 8'h00);
        chk({7'h00, ovf}, 8'h01);
        chk({7'h00, irq[0]}, 8'h01);
        pf(3'h0, 3'h1);
        chk({7'h00, ovf}, 8'h00);
        $display("test overflow done");
        @(posedge clk) sel <= 3'h0;
        pf(3'h7, 3'h0);
        for (i = 0; i < 8; i = i + 1) begin
            fo(2'(i));
            ms = fst(ms, 2'(i));
            chk({6'h00, sta, stb}, {6'h00, ms, ms});
            chk({7'h00, fla}, 8'h00);
            chk(cnt, 8'h00);
        end
        @(posedge clk) wml <= 2'h3;
        fo(2'h1);
        chk({6'h00, sta, stb}, {6'h00, ms, ms});
        $display("test force done");
        d = 8'($urandom);
        wr(1, d);
        wt(2);
        chk(rda, d);
        @(posedge clk) wmh <= 1'b1;
        wr(2, ~d);
        wt(2);
        chk(rdb, ~d);
        $display("test buffer done");
        @(posedge clk) begin wmh <= 1'b0; wml <= 2'h0; end
        wr(1, 8'h11);
        @(posedge clk) wml <= 2'h1;
        d = 8'h80 | 8'($urandom % 64);
        wr(1, d);
        pf(3'h7, 3'h0);
        wr(0, 8'hfe);
        @(posedge clk) sel <= 3'h1;
        tk(5'h01, 4);
        wt(6);
        chk(cnt, 8'hfc);
        chk({7'h00, ovf}, 8'h00);
        @(posedge clk) begin sel <= 3'h0; wml <= 2'h0; end
        wt(2);
        chk(rda, d);
        $display("test phase correct done");
        @(posedge clk) wml <= 2'h2;
        d = 8'h10 + 8'($urandom % 32);
        wr(1, d);
        pf(3'h7, 3'h0);
        wr(0, d - 8'h01);
        @(posedge clk) sel <= 3'h1;
        tk(5'h01, 3);
        wt(6);
        ms = ~ms;
        chk(cnt, 8'h01);
        chk({6'h00, fla, sta}, {6'h00, 1'b1, ms});
        $display("test clear on match done");
        fo(2'h3);
        chk({6'h00, sta, stb}, 8'h03);
        @(posedge clk) resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        wt(1);
        chk(cnt, 8'h00);
        chk({5'h00, bot, sta, stb}, 8'h04);
        chk(rda, 8'h00);
        $display("test second reset done");
        stop_test;
    end
endmodule // tcu_timer_bench
